// *** rtl/cpa_defs.vh ***
// Constants for the channel poll and boot-load attachment.
`ifndef CPA_DEFS_VH
`define CPA_DEFS_VH

// Register byte addresses on the APB side.
`define CPA_CTRL_ADDR      12'h000
`define CPA_STAT_ADDR      12'h004
`define CPA_ADDR_W         12

// Control register fields.
`define CPA_CTRL_LEVEL_LSB 0
`define CPA_CTRL_LEVEL_MSB 3
`define CPA_CTRL_IEN       4
`define CPA_CTRL_CS_REQ    5
`define CPA_CTRL_INT_REQ   6
`define CPA_CTRL_DEV_RST   7

// Status register fields.
`define CPA_STAT_CAPTURED  0
`define CPA_STAT_INT_PEND  1
`define CPA_STAT_CS_PEND   2
`define CPA_STAT_LOAD_TAG  3
`define CPA_STAT_XFER_EN   4
`define CPA_STAT_BOOT_ERR  5
`define CPA_STAT_DEV_END   6
`define CPA_STAT_SAMPLED   7
`define CPA_STAT_DUMMY     8

// Reset values.
`define CPA_LEVEL_RST      4'h0
`define CPA_IEN_RST        1'b0

// Poll identifier encodings: bit 0 marks an interrupt poll at the level
// in bits 1 to 4; bit 0 low with all level bits high is a cycle steal poll.
`define CPA_PID_INT_BIT    0
`define CPA_PID_CS_LEVEL   4'hF

// Status bus bits: 0 primary select, 1 alternate select, 3 error.
`define CPA_STS_PRIMARY    0
`define CPA_STS_ALTERNATE  1
`define CPA_STS_ERROR      3

// Deactivation limit after a channel reset, and its cycle count at 40 MHz.
`define CPA_CLK_PERIOD_NS  25
`define CPA_RST_DEGATE_NS  200
`define CPA_RST_DEGATE_CYC (`CPA_RST_DEGATE_NS / `CPA_CLK_PERIOD_NS)

// Default boot record length in transfers.
`define CPA_BOOT_WORDS     16

`endif

// *** rtl/cpa_top.v ***
// Channel poll mechanism and processor-initiated boot-load attachment.
`include "cpa_defs.vh"
`default_nettype none

// Overview of operation
// - Interrupt asserts the request line of its level.
// - Decode poll_identifier kinds; compare id bits 1-4 with level.
// - Sample latches freeze requests once the poll_identifier shows.
// - Decision defaults to propagate; tracks samples while idle.
// - Decision settles during the id-to-poll deskew.
// - Poll rise freezes decision; drives propagate or return.
// - Capture decision sets the capture latch at poll rise.
// - Request lines blocked until captured service ends.
// - Channel resets clear poll latches and tags, not device reset.
// - Device reset keeps cycle steal request; dummy service follows.
// - Device reset only clears the interrupt request source.
// - Device reset or level setup may withdraw an interrupt.
// - Jumpers make the device primary, alternate or no source.
// - System reset with start_boot_load and a jumper-selected status line clears the load tag.
// - First reset end sets tag; enable captures zero.
// - Second reset end clocks the tag into enable.
// - Reset with transfers enabled clears tag and enable.
// - Device reset is held as a long strobe.
// - Channel reset drops outputs in 200 ns; clears level.
// - Boot end drops tag; level zero, enabled, interrupt.
// - Status error stops boot, keeps tag, no interrupt.
module cpa_top #(
    parameter BOOT_WORDS = `CPA_BOOT_WORDS,
    parameter CNT_W      = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [4:0]  poll_identifier,
    input  wire        poll,
    input  wire        service_gate,
    input  wire [3:0]  status_bus,
    input  wire        system_reset,
    input  wire        halt_or_machine_check,
    input  wire        power_on_reset,
    input  wire        start_boot_load,
    input  wire        jumper_primary,
    input  wire        jumper_alternate,
    output reg  [15:0] request_in_bus,
    output reg         cycle_steal_request,
    output reg         poll_propagate,
    output reg         poll_return,
    output reg         service_gate_return,
    output reg         boot_load_tag
);

    localparam IN_W = 17;

    // Three-stage synchronisers; a bit changes once stages two and three agree.
    reg  [IN_W-1:0] sync1;
    reg  [IN_W-1:0] sync2;
    reg  [IN_W-1:0] sync3;
    reg  [IN_W-1:0] filt;
    wire [IN_W-1:0] raw_in;
    wire [IN_W-1:0] agree;

    assign raw_in = {jumper_alternate, jumper_primary, start_boot_load,
                     power_on_reset, halt_or_machine_check, system_reset,
                     status_bus, service_gate, poll, poll_identifier};
    assign agree = ~(sync2 ^ sync3);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= {IN_W{1'b0}};
            sync2 <= {IN_W{1'b0}};
            sync3 <= {IN_W{1'b0}};
            filt  <= {IN_W{1'b0}};
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= (sync3 & agree) | (filt & ~agree);
        end
    end

    wire [4:0] pid_f   = filt[4:0];
    wire       poll_f  = filt[5];
    wire       sgate_f = filt[6];
    wire [3:0] sts_f   = filt[10:7];
    wire       sysr_f  = filt[11];
    wire       halt_f  = filt[12];
    wire       por_f   = filt[13];
    wire       start_f = filt[14];
    wire       jpri_f  = filt[15];
    wire       jalt_f  = filt[16];

    // One-hot decode of a priority level onto the request-in lines.
    function [15:0] level_onehot;
        input [3:0] lvl;
        begin
            level_onehot = 16'h0001 << lvl;
        end
    endfunction

    // Control and status state.
    reg [3:0]       level;
    reg             int_enable;
    reg             cs_req;
    reg             int_req;
    reg             dev_rst;
    reg             dummy;
    reg             sampled_cs;
    reg             sampled_int;
    reg             sample_done;
    reg             decision;
    reg             poll_q;
    reg             captured;
    reg             cap_is_cs;
    reg             sysr_q;
    reg             armed;
    reg             xfer_en;
    reg             boot_err;
    reg             dev_end;
    reg [CNT_W-1:0] boot_cnt;

    wire chan_rst  = sysr_f | halt_f | por_f;
    wire id_int    = pid_f[`CPA_PID_INT_BIT];
    wire id_cs     = ~id_int & (pid_f[4:1] == `CPA_PID_CS_LEVEL);
    wire lvl_match = (pid_f[4:1] == level);
    wire int_live  = int_req & int_enable & ~cs_req;
    wire boot_sel  = (jpri_f & sts_f[`CPA_STS_PRIMARY]) |
                     (jalt_f & sts_f[`CPA_STS_ALTERNATE]);
    wire boot_run  = xfer_en & boot_load_tag & ~boot_err;
    wire svc_end   = service_gate_return & ~sgate_f;
    wire boot_last = (boot_cnt == BOOT_WORDS[CNT_W-1:0] - 1'b1);

    // APB decode: zero wait states, error on an unmapped word.
    wire wr_ctrl  = psel & penable & pwrite & (paddr == `CPA_CTRL_ADDR);
    wire unmapped = (paddr != `CPA_CTRL_ADDR) & (paddr != `CPA_STAT_ADDR);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & unmapped;

    // Read data is loaded in the setup cycle so it comes from a flip-flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable) begin
            if (paddr == `CPA_CTRL_ADDR) begin
                prdata <= {24'h000000, dev_rst, int_req, cs_req, int_enable,
                           level};
            end else if (paddr == `CPA_STAT_ADDR) begin
                prdata <= {23'h000000, dummy, sample_done, dev_end, boot_err,
                           xfer_en, boot_load_tag, cs_req, int_req, captured};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Poll mechanism, service answer and request sources.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level               <= `CPA_LEVEL_RST;
            int_enable          <= `CPA_IEN_RST;
            cs_req              <= 1'b0;
            int_req             <= 1'b0;
            dev_rst             <= 1'b0;
            dummy               <= 1'b0;
            sampled_cs          <= 1'b0;
            sampled_int         <= 1'b0;
            sample_done         <= 1'b0;
            decision            <= 1'b0;
            poll_q              <= 1'b0;
            captured            <= 1'b0;
            cap_is_cs           <= 1'b0;
            poll_propagate      <= 1'b0;
            poll_return         <= 1'b0;
            service_gate_return <= 1'b0;
            request_in_bus      <= 16'h0000;
            cycle_steal_request <= 1'b0;
            dev_end             <= 1'b0;
            boot_cnt            <= {CNT_W{1'b0}};
            boot_err            <= 1'b0;
        end else if (chan_rst) begin
            // The device reset bit is not part of this group.
            level               <= `CPA_LEVEL_RST;
            int_enable          <= `CPA_IEN_RST;
            cs_req              <= 1'b0;
            int_req             <= 1'b0;
            dummy               <= 1'b0;
            sampled_cs          <= 1'b0;
            sampled_int         <= 1'b0;
            sample_done         <= 1'b0;
            decision            <= 1'b0;
            poll_q              <= poll_f;
            captured            <= 1'b0;
            cap_is_cs           <= 1'b0;
            poll_propagate      <= 1'b0;
            poll_return         <= 1'b0;
            service_gate_return <= 1'b0;
            request_in_bus      <= 16'h0000;
            cycle_steal_request <= 1'b0;
            dev_end             <= 1'b0;
            boot_cnt            <= {CNT_W{1'b0}};
            boot_err            <= 1'b0;
        end else begin
            poll_q <= poll_f;

            // Software register writes.
            if (wr_ctrl) begin
                dev_rst <= pwdata[`CPA_CTRL_DEV_RST];
                if (pwdata[`CPA_CTRL_LEVEL_MSB:`CPA_CTRL_LEVEL_LSB] != level ||
                    pwdata[`CPA_CTRL_IEN] != int_enable) begin
                    // A level-setup write withdraws any presented interrupt.
                    int_req <= 1'b0;
                end else if (pwdata[`CPA_CTRL_INT_REQ]) begin
                    int_req <= 1'b1;
                end
                level      <= pwdata[`CPA_CTRL_LEVEL_MSB:`CPA_CTRL_LEVEL_LSB];
                int_enable <= pwdata[`CPA_CTRL_IEN];
                if (pwdata[`CPA_CTRL_CS_REQ] & ~boot_run) begin
                    cs_req <= 1'b1;
                end
                if (pwdata[`CPA_CTRL_INT_REQ]) begin
                    dev_end <= 1'b0;
                end
            end

            // Device reset is held for as long as software leaves the bit
            // set; it clears only the interrupt source, never a presented
            // cycle steal request or the capture latch.
            if (dev_rst) begin
                int_req <= 1'b0;
                if (cs_req) begin
                    dummy <= 1'b1;
                end
            end

            // Boot transfers raise cycle steal requests one at a time.
            if (boot_run & ~cs_req & ~captured) begin
                cs_req <= 1'b1;
            end

            // Sampling latches act only while poll is low, once per poll.
            if (!poll_f && !sample_done && (id_cs || id_int)) begin
                sampled_cs  <= id_cs & cs_req;
                sampled_int <= id_int & int_live;
                sample_done <= 1'b1;
            end

            // Between polls the decision follows the samples; no sample
            // means propagate. The id-to-poll deskew covers the sync delay.
            if (!poll_f) begin
                decision <= sampled_cs | (sampled_int & lvl_match);
            end

            if (poll_f & ~poll_q) begin
                poll_return    <= decision;
                poll_propagate <= ~decision;
                if (decision) begin
                    captured  <= 1'b1;
                    cap_is_cs <= sampled_cs;
                end
            end else if (~poll_f & poll_q) begin
                poll_return    <= 1'b0;
                poll_propagate <= 1'b0;
                if (!captured) begin
                    sampled_cs  <= 1'b0;
                    sampled_int <= 1'b0;
                    sample_done <= 1'b0;
                end
            end

            // Service answer for the captured request.
            if (captured & sgate_f) begin
                service_gate_return <= 1'b1;
            end
            if (svc_end) begin
                service_gate_return <= 1'b0;
                captured            <= 1'b0;
                sampled_cs          <= 1'b0;
                sampled_int         <= 1'b0;
                sample_done         <= 1'b0;
                if (cap_is_cs) begin
                    cs_req <= 1'b0;
                    dummy  <= 1'b0;
                    if (boot_run & ~dummy) begin
                        if (sts_f[`CPA_STS_ERROR]) begin
                            boot_err <= 1'b1;
                        end else if (boot_last) begin
                            // Boot record done: level zero, enabled, pending.
                            level      <= 4'h0;
                            int_enable <= 1'b1;
                            int_req    <= 1'b1;
                            dev_end    <= 1'b1;
                            boot_cnt   <= {CNT_W{1'b0}};
                        end else begin
                            boot_cnt <= boot_cnt + 1'b1;
                        end
                    end
                end else begin
                    int_req <= 1'b0;
                end
            end

            // Request presentation, blocked while a capture is in service.
            if (captured | (poll_f & ~poll_q & decision)) begin
                request_in_bus      <= 16'h0000;
                cycle_steal_request <= 1'b0;
            end else begin
                cycle_steal_request <= cs_req;
                request_in_bus      <= int_live ? level_onehot(level)
                                                : 16'h0000;
            end
        end
    end

    // Boot-load tag latch and transfer-enable trigger, driven by the
    // edges of system reset. A rising edge alone is never used, since
    // system reset may lead the start and status lines at the pins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysr_q        <= 1'b0;
            armed         <= 1'b0;
            boot_load_tag <= 1'b0;
            xfer_en       <= 1'b0;
        end else begin
            sysr_q <= sysr_f;
            if (por_f | halt_f) begin
                boot_load_tag <= 1'b0;
                xfer_en       <= 1'b0;
                armed         <= 1'b0;
            end else if (sysr_f) begin
                if (start_f & boot_sel) begin
                    boot_load_tag <= 1'b0;
                    xfer_en       <= 1'b0;
                    armed         <= 1'b1;
                end else if (xfer_en) begin
                    boot_load_tag <= 1'b0;
                    xfer_en       <= 1'b0;
                end
            end else if (sysr_q) begin
                if (armed) begin
                    boot_load_tag <= 1'b1;
                    xfer_en       <= 1'b0;
                    armed         <= 1'b0;
                end else begin
                    xfer_en <= boot_load_tag;
                end
            end else if (xfer_en & ~boot_err & svc_end & cap_is_cs &
                         ~dummy & boot_last & ~sts_f[`CPA_STS_ERROR]) begin
                // The tag stays up after an error so the failure can be seen.
                boot_load_tag <= 1'b0;
                xfer_en       <= 1'b0;
            end
        end
    end

endmodule // cpa_top

`default_nettype wire

// *** dv/cpa_chk.sv ***
// Port-level assertions for the channel poll and boot-load attachment.
`default_nettype none
module cpa_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        poll,
    input wire logic        service_gate,
    input wire logic        system_reset,
    input wire logic        halt_or_machine_check,
    input wire logic        power_on_reset,
    input wire logic        start_boot_load,
    input wire logic        jumper_primary,
    input wire logic [3:0]  status_bus,
    input wire logic [15:0] request_in_bus,
    input wire logic        cycle_steal_request,
    input wire logic        poll_propagate,
    input wire logic        poll_return,
    input wire logic        service_gate_return,
    input wire logic        boot_load_tag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Eight cycles is 200 ns at this clock rate.
    sequence s_chan_rst;
        (system_reset || halt_or_machine_check || power_on_reset)[*8];
    endsequence
    sequence s_load_rst;
        (system_reset && start_boot_load)[*8];
    endsequence
    sequence s_quiet_poll;
        $rose(poll) && !cycle_steal_request && request_in_bus == 16'h0000;
    endsequence
    AST_ONE_LINE: assert property (
        $onehot0(request_in_bus)) else $error("two request lines at once");
    AST_NOT_BOTH: assert property (
        !(cycle_steal_request && request_in_bus != 16'h0000))
        else $error("both request kinds presented");
    AST_PROP_IDLE: assert property (
        s_quiet_poll |-> ##[2:10] poll_propagate)
        else $error("idle poll not propagated");
    AST_RTN_POLL: assert property (
        $rose(poll_return) |-> poll && $past(poll, 2))
        else $error("return tag without poll");
    AST_RTN_HOLD: assert property (
        $rose(poll_return) |-> (poll_return && !poll_propagate)[*3])
        else $error("return tag not held");
    AST_SGR_CAUSE: assert property (
        $rose(service_gate_return) |-> service_gate && $past(service_gate, 2))
        else $error("service return without service gate");
    AST_SVC_BLOCK: assert property (
        service_gate_return |-> request_in_bus == 16'h0000
            && !cycle_steal_request) else $error("request during service");
    AST_CHAN_RST: assert property (
        s_chan_rst |-> !poll_return && !poll_propagate && !service_gate_return
            && !cycle_steal_request && request_in_bus == 16'h0000)
        else $error("outputs still active in channel reset");
    AST_LOAD_CLR: assert property (
        s_load_rst |-> !boot_load_tag) else $error("load tag not cleared");
    AST_LOAD_SET: assert property (
        $fell(system_reset) && start_boot_load && jumper_primary
            && status_bus[0] |-> ##[1:12] boot_load_tag)
        else $error("load tag not raised");
endmodule // cpa_chk
`default_nettype wire

// *** dv/cpa_chan_model.sv ***
// Behavioural channel side: one poll and, after a capture, its service.
`default_nettype none
module cpa_chan_model (
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [4:0] id,
    input  wire logic       poll_propagate,
    input  wire logic       poll_return,
    input  wire logic       service_gate_return,
    output logic      [4:0] poll_identifier,
    output logic            poll,
    output logic            service_gate,
    output logic            capt,
    output logic            done
);
    timeunit 1ns;
    timeprecision 1ps;
    int   n;
    logic c;
    initial begin
        {poll_identifier, poll, service_gate, capt, done} = '0;
        forever begin
            @(posedge pclk);
            done <= 1'b0;
            if (go) begin
                // Sequences run one at a time, never inside another one.
                poll_identifier <= id;
                repeat (8) @(posedge pclk);
                poll <= 1'b1;
                for (n = 0; n < 40 && !(poll_return || poll_propagate); n++)
                    @(posedge pclk);
                c = (n < 40) ? poll_return : 1'bx;
                // A random stall varies how long the tag must stand.
                repeat ($urandom_range(3)) @(posedge pclk);
                poll <= 1'b0;
                poll_identifier <= 5'h00;
                for (n = 0; n < 40 && (poll_return || poll_propagate); n++)
                    @(posedge pclk);
                if (c === 1'b1) begin
                    service_gate <= 1'b1;
                    for (n = 0; n < 40 && !service_gate_return; n++)
                        @(posedge pclk);
                    if (n == 40) c = 1'bx;
                    service_gate <= 1'b0;
                    for (n = 0; n < 40 && service_gate_return; n++)
                        @(posedge pclk);
                end
                capt <= c;
                done <= 1'b1;
            end
        end
    end
endmodule // cpa_chan_model
`default_nettype wire

// *** dv/cpa_tb.sv ***
// Self-checking bench for the channel poll and boot-load attachment.
`include "cpa_defs.vh"
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("BAD %s exp %0h got %0h", n, e, g); end end
`define WAIT(c) begin w = 0; while (!(c) && w < 3000) begin \
    @(posedge pclk); w++; end if (!(c)) begin err_total++; results(); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IEN = 32'h1 << `CPA_CTRL_IEN;
    localparam logic [31:0] CSR = 32'h1 << `CPA_CTRL_CS_REQ;
    localparam logic [31:0] INR = 32'h1 << `CPA_CTRL_INT_REQ;
    localparam logic [31:0] DRS = 32'h1 << `CPA_CTRL_DEV_RST;
    localparam logic [11:0] CTL = `CPA_CTRL_ADDR;
    localparam logic [11:0] STA = `CPA_STAT_ADDR;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        poll, service_gate, system_reset, halt_or_machine_check;
    logic        power_on_reset, start_boot_load, jumper_primary, go;
    logic        jumper_alternate, cycle_steal_request, poll_propagate;
    logic        poll_return, service_gate_return, boot_load_tag, capt, done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:0]  poll_identifier, id;
    logic [3:0]  status_bus, lvl, oth;
    logic [15:0] request_in_bus;
    logic [32:0] rd_q[$], e;
    logic        pl_q[$], pe;
    int          err_total, num_checks, w;
    cpa_top #(.BOOT_WORDS(4)) cpa_top_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .poll_identifier, .poll, .service_gate,
        .status_bus, .system_reset, .power_on_reset, .halt_or_machine_check,
        .start_boot_load, .jumper_primary, .jumper_alternate,
        .request_in_bus, .cycle_steal_request, .poll_return, .poll_propagate,
        .boot_load_tag, .service_gate_return);
    cpa_chan_model cpa_chan_model_inst (
        .pclk, .go, .id, .poll_propagate, .poll_return, .service_gate_return,
        .poll_identifier, .poll, .service_gate, .capt, .done);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = rd_q.pop_front();
            `CHK("apb read", e, {pslverr, prdata})
        end
        if (done) begin
            pe = pl_q.pop_front();
            `CHK("poll capture", pe, capt)
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) rd_q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        `WAIT(pready === 1'b1)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_poll(input logic [4:0] i, input logic c);
        @(posedge pclk);
        id <= i;
        go <= 1'b1;
        pl_q.push_back(c);
        @(posedge pclk);
        go <= 1'b0;
        `WAIT(done === 1'b1)
    endtask
    task automatic boot(input logic [1:0] j);
        @(posedge pclk);
        {jumper_alternate, jumper_primary} <= j;
        status_bus <= {2'b00, (j == 2'b00) ? 2'b01 : j};
        start_boot_load <= 1'b1;
        system_reset <= 1'b1;
        repeat (20) @(posedge pclk);
        `CHK("tag in reset", 1'b0, boot_load_tag)
        system_reset <= 1'b0;
        repeat (12) @(posedge pclk);
        `CHK("tag after reset", j != 2'b00, boot_load_tag)
        start_boot_load <= 1'b0;
        status_bus <= 4'h0;
        repeat (12) @(posedge pclk);
        `CHK("early request", 1'b0, cycle_steal_request)
        system_reset <= 1'b1;
        repeat (20) @(posedge pclk);
        system_reset <= 1'b0;
        repeat (12) @(posedge pclk);
        `CHK("tag kept", j != 2'b00, boot_load_tag)
        if (j != 2'b00) `WAIT(cycle_steal_request === 1'b1)
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, status_bus, system_reset} = '0;
        {halt_or_machine_check, power_on_reset, start_boot_load, go, id} = '0;
        {jumper_primary, jumper_alternate} = 2'b00;
        w = $urandom(4);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTL, 32'h0, 33'h0);
        apb(1'b0, STA, 32'h0, 33'h0);
        apb(1'b1, 12'h008, 32'hFFFF_FFFF, 33'h0);
        apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
        apb(1'b0, CTL, 32'h0, 33'h0);
        do_poll(5'h1E, 1'b0);
        for (int k = 0; k < 16; k++) begin
            lvl = 4'(k);
            oth = lvl + 4'($urandom_range(15, 1));
            apb(1'b1, CTL, IEN | lvl, 33'h0);
            apb(1'b1, CTL, IEN | INR | lvl, 33'h0);
            repeat (4) @(posedge pclk);
            `CHK("request line", 16'h1 << lvl, request_in_bus)
            do_poll({oth, 1'b1}, 1'b0);
            do_poll({lvl, 1'b1}, 1'b1);
            `CHK("after service", 16'h0000, request_in_bus)
            apb(1'b0, CTL, 32'h0, {1'b0, IEN | lvl});
        end
        repeat (2) apb(1'b1, CTL, IEN | INR | 32'h3, 33'h0);
        apb(1'b1, CTL, IEN | 32'h9, 33'h0);
        repeat (4) @(posedge pclk);
        `CHK("withdrawn", 16'h0000, request_in_bus)
        apb(1'b1, CTL, IEN | CSR | 32'h9, 33'h0);
        apb(1'b1, CTL, IEN | INR | 32'h9, 33'h0);
        repeat (4) @(posedge pclk);
        `CHK("int held back", 16'h0000, request_in_bus)
        apb(1'b1, CTL, DRS | IEN | 32'h9, 33'h0);
        apb(1'b1, CTL, IEN | 32'h9, 33'h0);
        repeat (4) @(posedge pclk);
        `CHK("cs survives", 1'b1, cycle_steal_request)
        do_poll(5'h1E, 1'b1);
        repeat (4) @(posedge pclk);
        `CHK("int cleared", 16'h0000, request_in_bus)
        for (int k = 0; k < 3; k++) begin
            repeat (2) apb(1'b1, CTL, IEN | INR | 32'h5, 33'h0);
            {power_on_reset, halt_or_machine_check, system_reset} <=
                3'b001 << k;
            repeat (10) @(posedge pclk);
            `CHK("reset drops request", 16'h0000, request_in_bus)
            {power_on_reset, halt_or_machine_check, system_reset} <= 3'b000;
            repeat (10) @(posedge pclk);
            apb(1'b0, CTL, 32'h0, 33'h0);
        end
        boot(2'b00);
        boot(2'b01);
        for (int k = 0; k < 4; k++) begin
            `WAIT(cycle_steal_request === 1'b1)
            do_poll(5'h1E, 1'b1);
        end
        `WAIT(boot_load_tag === 1'b0)
        repeat (4) @(posedge pclk);
        `CHK("boot end interrupt", 16'h0001, request_in_bus)
        apb(1'b0, CTL, 32'h0, {1'b0, IEN | INR});
        apb(1'b1, CTL, 32'h0, 33'h0);
        boot(2'b10);
        status_bus <= 4'h1 << `CPA_STS_ERROR;
        do_poll(5'h1E, 1'b1);
        status_bus <= 4'h0;
        repeat (20) @(posedge pclk);
        `CHK("stopped", 1'b0, cycle_steal_request)
        `CHK("tag kept on error", 1'b1, boot_load_tag)
        `CHK("no end interrupt", 16'h0000, request_in_bus)
        apb(1'b0, STA, 32'h0, 33'h38);
        system_reset <= 1'b1;
        repeat (20) @(posedge pclk);
        `CHK("third reset", 1'b0, boot_load_tag)
        system_reset <= 1'b0;
        results();
    end
endmodule // testbench
bind cpa_top cpa_chk cpa_chk_inst (
    .pclk, .presetn, .poll, .service_gate, .system_reset, .power_on_reset,
    .halt_or_machine_check, .status_bus, .start_boot_load, .jumper_primary,
    .request_in_bus, .poll_return, .cycle_steal_request, .boot_load_tag,
    .poll_propagate, .service_gate_return);
`default_nettype wire
